// ---- bench/ble_core_sleep_timebase_regs_test.sv ----
// Self-checking bench for the sleep, time base and address register bank
`timescale 1ns/1ns
module ble_core_sleep_timebase_regs_test;
	import bst_pkg::*;
	// ************************************************************
	// Signals and model
	// ************************************************************
	localparam int          FP        = 100;
	localparam logic [31:0] RW_A [4]  = '{BST_OFS_ADDR_LOW, BST_OFS_ADDR_HIGH, BST_OFS_RX_PTR,
		BST_OFS_SLP_TARGET};
	localparam logic [31:0] RW_M [4]  = '{32'hffff_ffff, 32'h0001_ffff, 32'hffff_7fff,
		32'hffff_ffff};
	logic                   clk_i;
	logic                   rst_i;
	bst_wb_req_type         wb_req_i;
	logic                   wb_ack_o;
	logic [31:0]            wb_dat_o;
	logic                   rx_done_i;
	logic                   lp_clk_i;
	logic                   ext_wake_i;
	logic                   lp_clk_sel_o;
	logic                   lowpower_wake_irq_o;
	logic                   irq_pending_o;
	int                     n_mismatch;
	int                     samples_checked;
	logic [31:0]            seed;
	logic [31:0]            q;
	logic [31:0]            u0;
	logic [31:0]            mdl [logic [31:0]];
	logic                   irq_seen;

	bst_regs #(.FINE_PERIOD_US(FP)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rx_done_i(rx_done_i), .lp_clk_i(lp_clk_i),
		.ext_wake_i(ext_wake_i), .lp_clk_sel_o(lp_clk_sel_o),
		.lowpower_wake_irq_o(lowpower_wake_irq_o), .irq_pending_o(irq_pending_o));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Slow clock runs free, toggles away from core rising edges
	initial begin
		lp_clk_i = 1'b0;
		forever #400 lp_clk_i = ~lp_clk_i;
	end
	always @(posedge clk_i) if (lowpower_wake_irq_o === 1'b1) irq_seen <= 1'b1;

	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Classic cycle; ack is sampled at the edge, so its pre-edge value is seen
	// Only the watchdog ends a hung wait; ack is due one cycle after the take
	task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		chk("bus wait", 32'd2, n);
		wb_req_i <= '0;
	endtask : bus
	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, exp, q & m);
	endtask : rdc
	task automatic waitsel(input logic v, input int lim);
		int n;
		n = 0;
		while (lp_clk_sel_o !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk("sleep status", {31'h0, v}, {31'h0, lp_clk_sel_o});
	endtask : waitsel
	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// Expected run is under 10000 cycles
	initial begin
		#(20000 * 100);
		n_mismatch++;
		close_out();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		n_mismatch = 0;
		samples_checked = 0;
		seed = 32'ha7aecf47;
		irq_seen = 1'b0;
		rst_i = 1'b1;
		wb_req_i = '0;
		rx_done_i = 1'b0;
		ext_wake_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) rdc("reset rw", RW_A[i], '1, 32'h0);
		rdc("reset dur", BST_OFS_SLP_DUR, '1, 32'h0);
		rdc("reset mask", BST_OFS_IRQ_MASK, '1, 32'h7);
		rdc("unmapped", 32'h4000_0070, '1, 32'h0);
		repeat (4) for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			bus(1'b1, RW_A[i], seed);
			mdl[RW_A[i]] = seed & RW_M[i];
			rdc("rw reg", RW_A[i], '1, mdl[RW_A[i]]);
		end
		bus(1'b1, BST_OFS_SLP_DUR, seed);
		rdc("ro dur", BST_OFS_SLP_DUR, '1, 32'h0);
		bus(1'b1, BST_OFS_IRQ_ACK, 32'h7);
		rdc("ack reads 0", BST_OFS_IRQ_ACK, '1, 32'h0);
		// Receive and tick flags, then clear both with one ack write
		@(posedge clk_i) rx_done_i <= 1'b1;
		@(posedge clk_i) rx_done_i <= 1'b0;
		rdc("rx flag", BST_OFS_IRQ_STAT, 32'h0002_0002, 32'h0002_0002);
		for (int n = 0; n < 500 && (q & 32'h1) == 0; n++) bus(1'b0, BST_OFS_IRQ_STAT, 32'h0);
		chk("tick flag", 32'h1, q & 32'h1);
		chk("pending", 32'h1, {31'h0, irq_pending_o});
		bus(1'b1, BST_OFS_IRQ_ACK, 32'h3);
		rdc("acked", BST_OFS_IRQ_STAT, 32'h0003_0003, 32'h0);
		chk("pending off", 32'h0, {31'h0, irq_pending_o});
		// Two snapshots 3010 cycles apart must differ by exactly 301 us
		bus(1'b1, BST_OFS_SAMPLE, 32'h1);
		// Exactly one tick has been seen since reset
		rdc("slot a", BST_OFS_SLOT_CNT, '1, 32'h1);
		u0 = q * FP;
		bus(1'b0, BST_OFS_FINE_CNT, 32'h0);
		chk("fine a range", 32'h1, {31'h0, q < FP});
		u0 = u0 + q;
		repeat (3001) @(posedge clk_i);
		bus(1'b1, BST_OFS_SAMPLE, 32'h1);
		bus(1'b0, BST_OFS_SLOT_CNT, 32'h0);
		u0 = q * FP - u0;
		bus(1'b0, BST_OFS_FINE_CNT, 32'h0);
		chk("fine range", 32'h1, {31'h0, q < FP});
		chk("elapsed us", 32'd301, u0 + q);
		// Timed sleep: target 6 slow cycles, wake irq lead 2
		bus(1'b1, BST_OFS_WAKE_TIME, 32'h2 << BST_LEAD_LSB);
		bus(1'b1, BST_OFS_SLP_TARGET, 32'h6);
		irq_seen = 1'b0;
		bus(1'b1, BST_OFS_SLP_CTRL, 32'h7);
		waitsel(1'b1, 100);
		rdc("asleep ctrl", BST_OFS_SLP_CTRL, 32'h8004, 32'h8004);
		waitsel(1'b0, 200);
		rdc("duration", BST_OFS_SLP_DUR, '1, 32'h6);
		chk("wake irq", 32'h1, {31'h0, irq_seen});
		rdc("awake ctrl", BST_OFS_SLP_CTRL, 32'h8004, 32'h0);
		rdc("sleep flag", BST_OFS_IRQ_STAT, 32'h0004_0004, 32'h0004_0004);
		bus(1'b1, BST_OFS_IRQ_ACK, 32'h4);
		rdc("sleep acked", BST_OFS_IRQ_STAT, 32'h0004_0004, 32'h0);
		bus(1'b1, BST_OFS_FINE_CORR, 32'h0);
		bus(1'b1, BST_OFS_SLOT_CORR, 32'h123);
		bus(1'b1, BST_OFS_SLP_CTRL, 32'h8);
		bus(1'b1, BST_OFS_SAMPLE, 32'h1);
		rdc("corrected", BST_OFS_SLOT_CNT, '1, 32'h123);
		rdc("corr cleared", BST_OFS_SLP_CTRL, 32'h8, 32'h0);
		// Software wake from a long sleep
		bus(1'b1, BST_OFS_SLP_TARGET, 32'd1000);
		bus(1'b1, BST_OFS_SLP_CTRL, 32'h7);
		waitsel(1'b1, 100);
		bus(1'b1, BST_OFS_SLP_CTRL, 32'h17);
		waitsel(1'b0, 40);
		rdc("wake cleared", BST_OFS_SLP_CTRL, 32'h14, 32'h0);
		// External wake held off while disabled, honoured once enabled
		bus(1'b1, BST_OFS_SLP_CTRL, 32'h8000_0007);
		waitsel(1'b1, 100);
		@(posedge clk_i) ext_wake_i <= 1'b1;
		repeat (60) @(posedge clk_i);
		chk("ext ignored", 32'h1, {31'h0, lp_clk_sel_o});
		bus(1'b1, BST_OFS_SLP_CTRL, 32'h7);
		waitsel(1'b0, 40);
		@(posedge clk_i) ext_wake_i <= 1'b0;
		close_out();
	end
endmodule : ble_core_sleep_timebase_regs_test

// ---- hw/bst_pkg.sv ----
// Package: register map, field layout, timing and carrier types
package bst_pkg;
	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [31:0] BST_OFS_IRQ_ACK    = 32'h4000_0018;
	localparam logic [31:0] BST_OFS_SLOT_CNT   = 32'h4000_001c;
	localparam logic [31:0] BST_OFS_FINE_CNT   = 32'h4000_0020;
	localparam logic [31:0] BST_OFS_ADDR_LOW   = 32'h4000_0024;
	localparam logic [31:0] BST_OFS_ADDR_HIGH  = 32'h4000_0028;
	localparam logic [31:0] BST_OFS_RX_PTR     = 32'h4000_002c;
	localparam logic [31:0] BST_OFS_SLP_CTRL   = 32'h4000_0030;
	localparam logic [31:0] BST_OFS_SLP_TARGET = 32'h4000_0034;
	localparam logic [31:0] BST_OFS_SLP_DUR    = 32'h4000_0038;
	localparam logic [31:0] BST_OFS_WAKE_TIME  = 32'h4000_003c;
	localparam logic [31:0] BST_OFS_FINE_CORR  = 32'h4000_0040;
	localparam logic [31:0] BST_OFS_SLOT_CORR  = 32'h4000_0044;
	localparam logic [31:0] BST_OFS_IRQ_STAT   = 32'h4000_0048;
	localparam logic [31:0] BST_OFS_IRQ_MASK   = 32'h4000_004c;
	localparam logic [31:0] BST_OFS_SAMPLE     = 32'h4000_0064;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int BST_ACK_SLEEP   = 2;
	localparam int BST_ACK_RX      = 1;
	localparam int BST_ACK_TICK    = 0;
	localparam int BST_PRIV_BIT    = 16;
	localparam int BST_EXT_DIS_BIT = 31;
	localparam int BST_STAT_BIT    = 15;
	localparam int BST_SW_WAKE_BIT = 4;
	localparam int BST_CORR_BIT    = 3;
	localparam int BST_SLP_ON_BIT  = 2;
	localparam int BST_LEAD_LSB    = 10;
	localparam int BST_LEAD_W      = 11;
	localparam int BST_MASKED_LSB  = 16;
	localparam int BST_SAMPLE_BIT  = 0;
	localparam int BST_SLOT_W      = 27;
	localparam int BST_FINE_W      = 10;
	localparam int BST_RXPTR_W     = 15;
	// ************************************************************
	// Reset values and timing
	// ************************************************************
	localparam logic [31:0] BST_RST_ZERO  = 32'h0000_0000;
	localparam logic [2:0]  BST_RST_MASK  = 3'h7;
	localparam int          BST_CLK_NS    = 100;
	localparam int          BST_US_NS     = 1000;
	localparam int          BST_SLOT_US   = 625;
	localparam int          BST_US_CYCLES = BST_US_NS / BST_CLK_NS;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		BST_ACTIVE = 2'b00,
		BST_ENTER  = 2'b01,
		BST_SLEEP  = 2'b10,
		BST_LEAVE  = 2'b11
	} bst_state_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [31:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} bst_wb_req_type;
endpackage : bst_pkg

// ---- hw/bst_regs.sv ----
// Link-layer sleep, time base and address registers on classic Wishbone
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
// How it works
// - Writing one to ack bit 2 clears raw and masked sleep-end flags.
// - Writing one to ack bit 1 clears raw and masked receive flags.
// - Writing one to ack bit 0 clears raw and masked tick flags.
// - 27-bit slot counter snapshot refreshes on every sample trigger write.
// - 10-bit fine counter snapshot refreshes on every sample trigger write.
// - Lower 32 device address bits held read/write, reset zero.
// - Upper 16 address bits plus private flag in bit 16.
// - Exchange table start in 31:16, receive chain start in 14:0.
// - Control bit 31 set makes the core ignore external wake-up.
// - Status bit 15 is one only while the low-power clock runs alone.
// - Writing one to bit 4 in deep sleep wakes the core, self-clears.
// - Writing one to bit 3 after wake applies correction, restarts counters.
// - Bit 2 requests deep sleep; cleared when sleep status falls.
// - 32-bit target count of low-power cycles sets sleep length.
// - Duration counter clears at sleep start, counts low-power cycles, holds.
// - Wake interrupt rises lead-time low-power cycles before sleep timer expiry.
module bst_regs #(
	parameter int FINE_PERIOD_US = 625
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Wishbone slave
	input  wire bst_pkg::bst_wb_req_type wb_req_i,
	output logic                         wb_ack_o,
	output logic [31:0]                  wb_dat_o,
	// Events and pins
	input  wire logic                    rx_done_i,
	input  wire logic                    lp_clk_i,
	input  wire logic                    ext_wake_i,
	// Sleep control and interrupt outputs
	output logic                         lp_clk_sel_o,
	output logic                         lowpower_wake_irq_o,
	output logic                         irq_pending_o
);
	import bst_pkg::*;

	if (FINE_PERIOD_US < 1 || FINE_PERIOD_US >= (1 << BST_FINE_W)) begin : g_chk
		$error("FINE_PERIOD_US must fit the fine counter");
	end

	localparam logic [BST_FINE_W-1:0] FINE_LAST = BST_FINE_W'(FINE_PERIOD_US - 1);
	localparam logic [3:0]            US_LAST   = 4'(BST_US_CYCLES - 1);

	// ************************************************************
	// Byte-lane merge, used by every writable register
	// ************************************************************
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// ************************************************************
	// Storage
	// ************************************************************
	logic                  ack_reg;
	logic [31:0]           rdat_reg;
	logic [31:0]           addr_low_reg;
	logic [16:0]           addr_high_reg;
	logic [15:0]           et_ptr_reg;
	logic [BST_RXPTR_W-1:0] rx_ptr_reg;
	logic                  ext_dis_reg;
	logic                  sw_wake_reg;
	logic                  corr_reg;
	logic                  sleep_req_reg;
	logic [1:0]            irq_en_reg;
	logic [31:0]           target_reg;
	logic [31:0]           dur_reg;
	logic [BST_LEAD_W-1:0] lead_reg;
	logic [BST_FINE_W-1:0] fine_corr_reg;
	logic [BST_SLOT_W-1:0] slot_corr_reg;
	logic [2:0]            raw_reg;
	logic [2:0]            mask_reg;
	logic [3:0]            us_reg;
	logic [BST_FINE_W-1:0] fine_reg;
	logic [BST_SLOT_W-1:0] slot_reg;
	logic [BST_FINE_W-1:0] fine_snap_reg;
	logic [BST_SLOT_W-1:0] slot_snap_reg;
	logic                  cnt_en_reg;
	logic                  lp_s1_reg;
	logic                  lp_s2_reg;
	logic                  lp_s3_reg;
	logic                  ext_s1_reg;
	logic                  ext_s2_reg;
	logic                  wake_irq_reg;
	bst_state_type         state_reg;
	bst_state_type         state_next;

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire        req_new  = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
	wire        wr_en    = req_new && wb_req_i.we;
	wire [31:0] adr      = wb_req_i.adr;
	wire [31:0] wdat     = merge(BST_RST_ZERO, wb_req_i.dat, wb_req_i.sel);
	wire        wr_ack   = wr_en && adr == BST_OFS_IRQ_ACK;
	wire        wr_ctrl  = wr_en && adr == BST_OFS_SLP_CTRL;
	wire        wr_samp  = wr_en && adr == BST_OFS_SAMPLE && wdat[BST_SAMPLE_BIT];
	wire [2:0]  ack_bits = wr_ack ? wdat[2:0] : 3'h0;
	wire        in_sleep = state_reg == BST_SLEEP;
	wire        slp_stat = state_reg == BST_SLEEP || state_reg == BST_LEAVE;

	// ************************************************************
	// Time base
	// ************************************************************
	wire us_wrap   = us_reg == US_LAST;
	wire fine_wrap = us_wrap && fine_reg == FINE_LAST;
	wire tick_set  = cnt_en_reg && fine_wrap;
	wire lp_edge   = lp_s2_reg && !lp_s3_reg;
	wire [31:0] dur_inc  = dur_reg + 32'h1;
	wire [31:0] remain   = target_reg - dur_reg;
	wire        ext_wake = ext_s2_reg && !ext_dis_reg;
	wire        expired  = lp_edge && dur_inc >= target_reg;
	wire        wake_now = sw_wake_reg || ext_wake || expired;
	wire        slp_set  = state_reg == BST_LEAVE && lp_edge;
	wire [2:0]  ev_set   = {slp_set, rx_done_i, tick_set};
	wire [2:0]  masked   = raw_reg & mask_reg;
	wire        lead_hit = target_reg > dur_reg && remain <= 32'(lead_reg);

	// ************************************************************
	// Sleep sequencer
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			BST_ACTIVE: if (sleep_req_reg) begin
				state_next = BST_ENTER;
			end
			BST_ENTER: if (lp_edge) begin
				state_next = BST_SLEEP;
			end
			BST_SLEEP: if (wake_now) begin
				state_next = BST_LEAVE;
			end
			BST_LEAVE: if (lp_edge) begin
				state_next = BST_ACTIVE;
			end
		endcase
	end

	// ************************************************************
	// Read mux
	// ************************************************************
	function automatic logic [31:0] rd_mux(input logic [31:0] a);
		logic [31:0] r;
		r = BST_RST_ZERO;
		unique case (a)
			BST_OFS_SLOT_CNT:   r = 32'(slot_snap_reg);
			BST_OFS_FINE_CNT:   r = 32'(fine_snap_reg);
			BST_OFS_ADDR_LOW:   r = addr_low_reg;
			BST_OFS_ADDR_HIGH:  r = 32'(addr_high_reg);
			BST_OFS_RX_PTR:     r = {et_ptr_reg, 1'b0, rx_ptr_reg};
			BST_OFS_SLP_CTRL:   r = {ext_dis_reg, 15'h0, slp_stat, 10'h0,
				sw_wake_reg, corr_reg, sleep_req_reg, irq_en_reg};
			BST_OFS_SLP_TARGET: r = target_reg;
			BST_OFS_SLP_DUR:    r = dur_reg;
			BST_OFS_WAKE_TIME:  r = {11'h0, lead_reg, 10'h0};
			BST_OFS_FINE_CORR:  r = 32'(fine_corr_reg);
			BST_OFS_SLOT_CORR:  r = 32'(slot_corr_reg);
			BST_OFS_IRQ_STAT:   r = {13'h0, masked, 13'h0, raw_reg};
			BST_OFS_IRQ_MASK:   r = 32'(mask_reg);
			default:            r = BST_RST_ZERO;
		endcase
		return r;
	endfunction : rd_mux

	// ************************************************************
	// Bus slave: one wait state, unmapped reads zero
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= BST_RST_ZERO;
		end else begin
			ack_reg  <= req_new;
			rdat_reg <= req_new && !wb_req_i.we ? rd_mux(adr) : BST_RST_ZERO;
		end
	end

	// ************************************************************
	// Plain storage registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_low_reg  <= BST_RST_ZERO;
			addr_high_reg <= '0;
			et_ptr_reg    <= '0;
			rx_ptr_reg    <= '0;
			target_reg    <= BST_RST_ZERO;
			lead_reg      <= '0;
			fine_corr_reg <= '0;
			slot_corr_reg <= '0;
			mask_reg      <= BST_RST_MASK;
		end else if (wr_en) begin
			unique case (adr)
				BST_OFS_ADDR_LOW:   addr_low_reg  <= merge(addr_low_reg, wb_req_i.dat,
					wb_req_i.sel);
				BST_OFS_ADDR_HIGH:  addr_high_reg <= 17'(merge(32'(addr_high_reg),
					wb_req_i.dat, wb_req_i.sel));
				BST_OFS_RX_PTR: begin
					et_ptr_reg <= 16'(merge(32'(et_ptr_reg) << 16, wb_req_i.dat,
						wb_req_i.sel) >> 16);
					rx_ptr_reg <= BST_RXPTR_W'(merge(32'(rx_ptr_reg), wb_req_i.dat,
						wb_req_i.sel));
				end
				BST_OFS_SLP_TARGET: target_reg    <= merge(target_reg, wb_req_i.dat,
					wb_req_i.sel);
				BST_OFS_WAKE_TIME:  lead_reg      <= wdat[BST_LEAD_LSB +: BST_LEAD_W];
				BST_OFS_FINE_CORR:  fine_corr_reg <= wdat[BST_FINE_W-1:0];
				BST_OFS_SLOT_CORR:  slot_corr_reg <= wdat[BST_SLOT_W-1:0];
				BST_OFS_IRQ_MASK:   mask_reg      <= wdat[2:0];
				default:            mask_reg      <= mask_reg;
			endcase
		end
	end

	// ************************************************************
	// Sleep control bits
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_dis_reg   <= 1'b0;
			irq_en_reg    <= 2'h0;
			sleep_req_reg <= 1'b0;
			sw_wake_reg   <= 1'b0;
			corr_reg      <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ext_dis_reg <= wdat[BST_EXT_DIS_BIT];
				irq_en_reg  <= wdat[1:0];
			end
			// Set wins over the hardware clear in the same cycle
			if (wr_ctrl && wdat[BST_SLP_ON_BIT]) begin
				sleep_req_reg <= 1'b1;
			end else if (wr_ctrl) begin
				sleep_req_reg <= 1'b0;
			end else if (slp_set) begin
				sleep_req_reg <= 1'b0;
			end
			// A wake written outside sleep has nothing to act on
			if (wr_ctrl && wdat[BST_SW_WAKE_BIT] && in_sleep) begin
				sw_wake_reg <= 1'b1;
			end else if (!in_sleep) begin
				sw_wake_reg <= 1'b0;
			end
			corr_reg <= wr_ctrl && wdat[BST_CORR_BIT]
				&& state_reg == BST_ACTIVE;
		end
	end

	// ************************************************************
	// Interrupt flags and sleep sequencer state
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw_reg      <= 3'h0;
			state_reg    <= BST_ACTIVE;
			dur_reg      <= BST_RST_ZERO;
			wake_irq_reg <= 1'b0;
		end else begin
			raw_reg      <= (raw_reg & ~ack_bits) | ev_set;
			state_reg    <= state_next;
			wake_irq_reg <= in_sleep && irq_en_reg != 2'h0 && lead_hit;
			if (state_reg == BST_ENTER && lp_edge) begin
				dur_reg <= BST_RST_ZERO;
			end else if (in_sleep && lp_edge) begin
				dur_reg <= dur_inc;
			end
		end
	end

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp_s1_reg  <= 1'b0;
			lp_s2_reg  <= 1'b0;
			lp_s3_reg  <= 1'b0;
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
		end else begin
			lp_s1_reg  <= lp_clk_i;
			lp_s2_reg  <= lp_s1_reg;
			lp_s3_reg  <= lp_s2_reg;
			ext_s1_reg <= ext_wake_i;
			ext_s2_reg <= ext_s1_reg;
		end
	end

	// ************************************************************
	// Fine and slot counters; frozen from sleep until correction
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			us_reg        <= 4'h0;
			fine_reg      <= '0;
			slot_reg      <= '0;
			cnt_en_reg    <= 1'b1;
			fine_snap_reg <= '0;
			slot_snap_reg <= '0;
		end else begin
			if (wr_samp) begin
				fine_snap_reg <= fine_reg;
				slot_snap_reg <= slot_reg;
			end
			if (state_reg == BST_ENTER && lp_edge) begin
				cnt_en_reg <= 1'b0;
			end else if (corr_reg) begin
				cnt_en_reg <= 1'b1;
				fine_reg   <= fine_corr_reg;
				slot_reg   <= slot_corr_reg;
				us_reg     <= 4'h0;
			end else if (cnt_en_reg) begin
				us_reg <= us_wrap ? 4'h0 : us_reg + 4'h1;
				if (fine_wrap) begin
					fine_reg <= '0;
					slot_reg <= slot_reg + 1'b1;
				end else if (us_wrap) begin
					fine_reg <= fine_reg + 1'b1;
				end
			end
		end
	end

	assign wb_ack_o            = ack_reg;
	assign wb_dat_o            = rdat_reg;
	assign lp_clk_sel_o        = slp_stat;
	assign lowpower_wake_irq_o = wake_irq_reg;
	assign irq_pending_o       = |masked;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_sleep_entry;
		state_reg == BST_ENTER && lp_edge;
	endsequence

	property p_ack_sleep;
		ack_bits[BST_ACK_SLEEP] && !slp_set |=> !raw_reg[2] && !masked[2];
	endproperty
	a_ack_sleep: assert property (p_ack_sleep) else $error("sleep flag not cleared");
	property p_ack_rx;
		ack_bits[BST_ACK_RX] && !rx_done_i |=> !raw_reg[1] && !masked[1];
	endproperty
	a_ack_rx: assert property (p_ack_rx) else $error("rx flag not cleared");
	property p_ack_tick;
		ack_bits[BST_ACK_TICK] && !tick_set |=> !raw_reg[0];
	endproperty
	a_ack_tick: assert property (p_ack_tick) else $error("tick flag not cleared");
	property p_snap;
		wr_samp |=> slot_snap_reg == $past(slot_reg) && fine_snap_reg == $past(fine_reg);
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot mismatch");
	property p_ext_ignored;
		in_sleep && ext_dis_reg && !sw_wake_reg && !lp_edge |=> in_sleep;
	endproperty
	a_ext_ignored: assert property (p_ext_ignored) else $error("external wake not ignored");
	property p_sw_wake;
		in_sleep && sw_wake_reg |=> state_reg == BST_LEAVE ##1 !sw_wake_reg;
	endproperty
	a_sw_wake: assert property (p_sw_wake) else $error("soft wake failed");
	property p_corr;
		corr_reg |=> cnt_en_reg && fine_reg == $past(fine_corr_reg);
	endproperty
	a_corr: assert property (p_corr) else $error("correction not applied");
	property p_req_clear;
		$fell(lp_clk_sel_o) && !$past(wr_ctrl) |-> !sleep_req_reg;
	endproperty
	a_req_clear: assert property (p_req_clear) else $error("sleep request kept");
	property p_dur_clear;
		s_sleep_entry |=> dur_reg == 32'h0 && lp_clk_sel_o && !cnt_en_reg;
	endproperty
	a_dur_clear: assert property (p_dur_clear) else $error("duration not cleared");
	property p_stat_rise;
		$rose(lp_clk_sel_o) |-> $past(state_reg) == BST_ENTER && $past(lp_edge);
	endproperty
	a_stat_rise: assert property (p_stat_rise) else $error("status rose early");
endmodule : bst_regs
